// ===== verilog/sdc_top.sv
`timescale 1ns/10ps
// Shadow attribute and DRAM timing configuration bank
module sdc_top #(
   parameter int DW = sdc_pkg::SDC_DATA_W,
   parameter int AW = sdc_pkg::SDC_ADDR_W
) (
   // Clock, reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,

   // AXI4-Lite register port
   input  wire logic [AW-1:0]              s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [DW-1:0]              s_axi_wdata,
   input  wire logic [DW/8-1:0]            s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [AW-1:0]              s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [DW-1:0]                   s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,

   // Memory access to classify
   input  wire logic                       acc_valid,
   input  wire logic [sdc_pkg::SDC_ACC_AW-1:0] acc_addr,
   input  wire logic                       acc_write,
   input  wire logic                       acc_pci_master,
   input  wire logic                       dram_prog_state,

   // Access classification, one cycle after the access
   output logic                            acc_hit,
   output logic                            acc_to_dram,
   output logic                            acc_to_expansion,
   output logic                            acc_cacheable,

   // Controller configuration
   // Shadow, refresh
   output logic                            pbsram_b2b_en,
   output logic                            pci_shadow_en,
   output logic                            refresh_advanced,
   // Clock tuning
   output logic                            aclk_to_row_strobe_two,
   output logic                            auto_bank_en,
   output logic [4:0]                      aclk_delay_tap,
   output logic                            aclk_internal_sel,
   // DRAM cycles
   output logic                            enhanced_post_write_en,
   output logic                            burst_extended_data_out_dram_write_1t,
   output logic                            write_cas_before_ras_cycle_en,
   output logic                            dram_burst_5x_en
);
   // Bank sizes
   localparam int NREG = sdc_pkg::SDC_NREG;
   localparam int NSEG = sdc_pkg::SDC_NSEG;

   sdc_regbus_if #(.AW(AW)) bus ();          // Strobes from the bus slave

   // Register bank
   logic [7:0]      regs_q [NREG];           // Register storage
   logic [7:0]      regs_d [NREG];           // Next register values
   logic [NREG-1:0] wr_hit;                  // Write addressed to register
   logic [NREG-1:0] wr_match;                // Write address matches register
   logic            prog_prev_q;             // Programming state, one cycle old
   logic            prog_exit;               // Programming state just left

   // Classifier
   logic [2:0]      seg_attr [NSEG];         // Read, cache, write per segment
   logic [NSEG-1:0] seg_match;               // Access falls in segment
   logic [NSEG-1:0] seg_rd;                  // Readable segment hit
   logic            hit_q, hit_d;            // Access in governed range
   logic            dram_q, dram_d;          // Served from shadow DRAM
   logic            exp_q, exp_d;            // Forwarded to expansion bus
   logic            cache_q, cache_d;        // Cache may allocate

   // Read path
   logic [7:0]      rd_val;                  // Read mux result
   logic            rd_found;                // Read address mapped

   // Bus handshakes live in the front end
   sdc_axil_slave #(.DW(DW), .AW(AW)) u_slave (
      .sys_clk (sys_clk),
      .rst     (rst),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .bus     (bus)
   );

   // Exit of the programming state is a falling level
   assign prog_exit = prog_prev_q & ~dram_prog_state;

   // Per-register write decode and next value
   for (genvar g = 0; g < NREG; g++) begin : g_reg
      // Word index match; low two address bits ignored
      assign wr_match[g] = (bus.wr_addr[AW-1:2] == (AW-2)'(sdc_pkg::SDC_REG_IDX[g]));
      // Lane 0 carries the byte; without its strobe nothing changes
      assign wr_hit[g] = bus.wr_en & bus.wr_strb & wr_match[g];
      always_comb begin
         // Hold by default
         regs_d[g] = regs_q[g];
         if (wr_hit[g]) begin
            // Reserved bits forced to zero so they read back as zero
            regs_d[g] = bus.wr_data & sdc_pkg::SDC_REG_MASK[g];
         end else if (g == sdc_pkg::SDC_R_DRAM && prog_exit) begin
            // Software write in the exit cycle wins over the auto clear
            regs_d[g][sdc_pkg::SDC_B_WRITE_CAS_BEFORE_RAS_CYCLE] = 1'b0;
         end
      end
   end

   // Mapped: OKAY
   assign bus.wr_ok = |wr_match;

   // Read mux: unmapped words answer zero with an error
   always_comb begin
      // Unmapped default
      rd_val   = 8'h00;
      rd_found = 1'b0;
      for (int i = 0; i < NREG; i++) begin
         if (bus.rd_addr[AW-1:2] == (AW-2)'(sdc_pkg::SDC_REG_IDX[i])) begin
            rd_val   = regs_q[i];
            rd_found = 1'b1;
         end
      end
   end

   // Answer to slave
   assign bus.rd_data = rd_val;
   assign bus.rd_ok   = rd_found;

   // Register bank and programming state history
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // Reset values
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= sdc_pkg::SDC_REG_RST;
         end
         prog_prev_q <= 1'b0;
      end else begin
         // Next values
         for (int i = 0; i < NREG; i++) begin
            regs_q[i] <= regs_d[i];
         end
         prog_prev_q <= dram_prog_state;
      end
   end

   // Option segments: two per register, upper group first
   for (genvar s = 0; s < NSEG; s++) begin : g_seg
      // Slots of segment
      localparam int RI = sdc_pkg::SDC_R_SEG_D8 + s / 2;
      localparam int BR = (s % 2 == 0) ? sdc_pkg::SDC_B_RD_HI : sdc_pkg::SDC_B_RD_LO;
      localparam int BC = (s % 2 == 0) ? sdc_pkg::SDC_B_CA_HI : sdc_pkg::SDC_B_CA_LO;
      localparam int BW = (s % 2 == 0) ? sdc_pkg::SDC_B_WR_HI : sdc_pkg::SDC_B_WR_LO;
      assign seg_attr[s]  = {regs_q[RI][BR], regs_q[RI][BC], regs_q[RI][BW]};
      // Segment number
      assign seg_match[s] = (acc_addr[sdc_pkg::SDC_ACC_AW-1:sdc_pkg::SDC_SEG_LSB]
                             == 6'(sdc_pkg::SDC_SEG_FIRST + 6'(s)));
      assign seg_rd[s]    = seg_match[s] & seg_attr[s][sdc_pkg::SDC_A_RD];
   end

   // Access classification
   always_comb begin
      logic [2:0] attr;
      logic       allowed;

      // Outside all ranges
      attr    = 3'b000;
      hit_d   = 1'b0;
      allowed = 1'b0;
      // Ranges disjoint
      for (int s = 0; s < NSEG; s++) begin
         if (seg_match[s]) begin
            attr  = seg_attr[s];
            hit_d = 1'b1;
         end
      end

      // BIOS area uses the upper group of its own register
      if (acc_addr[sdc_pkg::SDC_ACC_AW-1:sdc_pkg::SDC_BIOS_LSB] == sdc_pkg::SDC_BIOS_TAG) begin
         attr  = {regs_q[sdc_pkg::SDC_R_BIOS][sdc_pkg::SDC_B_RD_HI],
                  regs_q[sdc_pkg::SDC_R_BIOS][sdc_pkg::SDC_B_CA_HI],
                  regs_q[sdc_pkg::SDC_R_BIOS][sdc_pkg::SDC_B_WR_HI]};
         hit_d = 1'b1;
      end
      // Valid only
      hit_d = hit_d & acc_valid;

      // Direction picks which enable applies
      allowed = acc_write ? attr[sdc_pkg::SDC_A_WR] : attr[sdc_pkg::SDC_A_RD];

      // PCI masters see shadow only when permitted
      if (acc_pci_master && !regs_q[sdc_pkg::SDC_R_BIOS][sdc_pkg::SDC_B_PCI_SHADOW]) begin
         allowed = 1'b0;
      end

      // Refused: expansion
      dram_d  = hit_d & allowed;
      exp_d   = hit_d & ~allowed;

      // Cacheability is independent of routing
      cache_d = hit_d & attr[sdc_pkg::SDC_A_CA];
   end

   // Classification is registered; one cycle of latency
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // Nothing classified
         hit_q   <= 1'b0;
         dram_q  <= 1'b0;
         exp_q   <= 1'b0;
         cache_q <= 1'b0;
      end else begin
         // One cycle latency
         hit_q   <= hit_d;
         dram_q  <= dram_d;
         exp_q   <= exp_d;
         cache_q <= cache_d;
      end
   end

   // Flop outputs
   assign acc_hit          = hit_q;
   assign acc_to_dram      = dram_q;
   assign acc_to_expansion = exp_q;
   assign acc_cacheable    = cache_q;

   // Configuration straight from register flops
   // Shadow, refresh
   assign pbsram_b2b_en          = regs_q[sdc_pkg::SDC_R_SEG_D8][sdc_pkg::SDC_B_B2B];
   assign pci_shadow_en          = regs_q[sdc_pkg::SDC_R_BIOS][sdc_pkg::SDC_B_PCI_SHADOW];
   assign refresh_advanced       = regs_q[sdc_pkg::SDC_R_BIOS][sdc_pkg::SDC_B_REFRESH];

   // Clock tuning
   // Only for delay tuning; software must keep it off with offset 64 bits 0 and 2
   assign aclk_to_row_strobe_two = regs_q[sdc_pkg::SDC_R_CLK][sdc_pkg::SDC_B_ACLK_RS2];
   assign auto_bank_en           = regs_q[sdc_pkg::SDC_R_CLK][sdc_pkg::SDC_B_AUTO_BANK];
   // One-hot tap; zero selects the shortest delay
   assign aclk_delay_tap         = regs_q[sdc_pkg::SDC_R_CLK][sdc_pkg::SDC_B_DLY_HI:sdc_pkg::SDC_B_DLY_LO];
   assign aclk_internal_sel      = regs_q[sdc_pkg::SDC_R_CLK][sdc_pkg::SDC_B_ACLK_INT];

   // DRAM cycles
   assign enhanced_post_write_en = regs_q[sdc_pkg::SDC_R_DRAM][sdc_pkg::SDC_B_POST_WR];
   assign burst_extended_data_out_dram_write_1t = regs_q[sdc_pkg::SDC_R_DRAM][sdc_pkg::SDC_B_BURST_EXTENDED_DATA_OUT_DRAM_1T];
   assign write_cas_before_ras_cycle_en = regs_q[sdc_pkg::SDC_R_DRAM][sdc_pkg::SDC_B_WRITE_CAS_BEFORE_RAS_CYCLE];
   assign dram_burst_5x_en       = regs_q[sdc_pkg::SDC_R_DRAM][sdc_pkg::SDC_B_BURST5];

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Falling level
   sequence s_prog_exit;
      dram_prog_state ##1 !dram_prog_state;
   endsequence

   // Tuning zero
   property p_clk_reset;
      rst |=> (regs_q[sdc_pkg::SDC_R_CLK] == 8'h00) && (regs_q[sdc_pkg::SDC_R_DRAM] == 8'h00);
   endproperty
   a_clk_reset: assert property (disable iff (1'b0) p_clk_reset) else $error("tuning regs not zero");

   // Auto clear
   property p_prog_clear;
      (s_prog_exit ##0 !wr_hit[sdc_pkg::SDC_R_DRAM]) |=> !write_cas_before_ras_cycle_en;
   endproperty
   a_prog_clear: assert property (p_prog_clear) else $error("program enable kept");

   // Tap written
   property p_tap_write;
      wr_hit[sdc_pkg::SDC_R_CLK] |=>
         aclk_delay_tap == $past(bus.wr_data[sdc_pkg::SDC_B_DLY_HI:sdc_pkg::SDC_B_DLY_LO]);
   endproperty
   a_tap_write: assert property (p_tap_write) else $error("delay tap not written");

   // Read off: expansion
   property p_read_off;
      (acc_valid && !acc_write && (|seg_match) && !(|seg_rd))
         |=> acc_to_expansion && !acc_to_dram;
   endproperty
   a_read_off: assert property (p_read_off) else $error("read not forwarded");

   // One route
   property p_route_excl;
      !(acc_to_dram && acc_to_expansion) && ((acc_to_dram || acc_to_expansion) == acc_hit);
   endproperty
   a_route_excl: assert property (p_route_excl) else $error("routing inconsistent");

   // Cache on hit
   property p_cache;
      acc_cacheable |-> $past(acc_valid) && acc_hit;
   endproperty
   a_cache: assert property (p_cache) else $error("cacheable outside range");

   // PCI blocked
   property p_pci_block;
      (acc_valid && acc_pci_master && !pci_shadow_en) |=> !acc_to_dram;
   endproperty
   a_pci_block: assert property (p_pci_block) else $error("PCI reached shadow");

   // BIOS shadowed
   property p_bios_read;
      (acc_valid && !acc_write && !acc_pci_master
         && acc_addr[sdc_pkg::SDC_ACC_AW-1:sdc_pkg::SDC_BIOS_LSB] == sdc_pkg::SDC_BIOS_TAG
         && regs_q[sdc_pkg::SDC_R_BIOS][sdc_pkg::SDC_B_RD_HI]) |=> acc_to_dram;
   endproperty
   a_bios_read: assert property (p_bios_read) else $error("BIOS read not shadowed");

   // Burst written
   property p_burst5;
      wr_hit[sdc_pkg::SDC_R_DRAM] |=> dram_burst_5x_en == $past(bus.wr_data[sdc_pkg::SDC_B_BURST5]);
   endproperty
   a_burst5: assert property (p_burst5) else $error("burst timing not written");

   // B2B written
   property p_b2b;
      wr_hit[sdc_pkg::SDC_R_SEG_D8] |=> pbsram_b2b_en == $past(bus.wr_data[sdc_pkg::SDC_B_B2B]);
   endproperty
   a_b2b: assert property (p_b2b) else $error("back-to-back bit not written");
endmodule // sdc_top

// ===== verilog/sdc_pkg.sv
// Operation
// - Each segment-register attribute triple governs one 16 KB segment
// - BIOS register upper bits govern BIOS region
// - Bit 0 selects burst SRAM back-to-back timing
// - BIOS bit 3 lets PCI masters reach shadow
// - BIOS bit 0 selects refresh arbitration style
// - Clock-tuning bit 7 routes clock to row strobe
// - Bit 6 enables automatic banking for 32-bit DRAM
// - Bits 5:1 select one-hot clock delay tap
// - Bit 0 selects internal or external clock
// - Cycle options bit 7 enables enhanced posted writes
// - Bit 2 sets burst EDO write cycle time
// - Bit 1 enables mode-programming cycle
// - Programming enable clears when programming state exits; a cycle-options write in the exit cycle wins
// - Bit 0 enables 5-X-X-X-X burst timing
// - Clock-tuning registers reset to zero
package sdc_pkg;
   localparam int         SDC_DATA_W  = 32;            // Bus data width
   localparam int         SDC_ADDR_W  = 12;            // Bus address bits decoded
   localparam int         SDC_NREG    = 6;             // Registers in the bank
   // Register indices; byte address is four times the index
   localparam logic [7:0] SDC_IDX_SEG_D8  = 8'h83;
   localparam logic [7:0] SDC_IDX_SEG_E0  = 8'h84;
   localparam logic [7:0] SDC_IDX_SEG_E8  = 8'h85;
   localparam logic [7:0] SDC_IDX_BIOS    = 8'h86;
   localparam logic [7:0] SDC_IDX_CLK     = 8'ha4;
   localparam logic [7:0] SDC_IDX_DRAM    = 8'ha5;
   localparam logic [7:0] SDC_REG_IDX [SDC_NREG] = '{SDC_IDX_SEG_D8, SDC_IDX_SEG_E0, SDC_IDX_SEG_E8,
                                                    SDC_IDX_BIOS, SDC_IDX_CLK, SDC_IDX_DRAM};
   // Writable bits per register; the rest read as zero
   localparam logic [7:0] SDC_REG_MASK [SDC_NREG] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h87};
   localparam logic [7:0] SDC_REG_RST  = 8'h00;        // Reset value of every register
   // Positions of registers in the storage array
   localparam int         SDC_R_SEG_D8 = 0;
   localparam int         SDC_R_BIOS   = 3;
   localparam int         SDC_R_CLK    = 4;
   localparam int         SDC_R_DRAM   = 5;
   // Attribute group bit positions
   localparam int         SDC_B_RD_HI = 7;
   localparam int         SDC_B_CA_HI = 6;
   localparam int         SDC_B_WR_HI = 5;
   localparam int         SDC_B_RD_LO = 3;
   localparam int         SDC_B_CA_LO = 2;
   localparam int         SDC_B_WR_LO = 1;
   // Single control bits
   localparam int         SDC_B_B2B        = 0;
   localparam int         SDC_B_PCI_SHADOW = 3;
   localparam int         SDC_B_REFRESH    = 0;
   localparam int         SDC_B_ACLK_RS2   = 7;
   localparam int         SDC_B_AUTO_BANK  = 6;
   localparam int         SDC_B_DLY_HI     = 5;
   localparam int         SDC_B_DLY_LO     = 1;
   localparam int         SDC_B_ACLK_INT   = 0;
   localparam int         SDC_B_POST_WR    = 7;
   localparam int         SDC_B_BURST_EXTENDED_DATA_OUT_DRAM_1T    = 2;
   localparam int         SDC_B_WRITE_CAS_BEFORE_RAS_CYCLE       = 1;
   localparam int         SDC_B_BURST5     = 0;
   // Memory access decode
   localparam int         SDC_ACC_AW    = 20;          // Address bits within first megabyte
   localparam int         SDC_SEG_LSB   = 14;          // 16 KB segment granule
   localparam int         SDC_NSEG      = 6;           // Option segments in this bank
   localparam logic [5:0] SDC_SEG_FIRST = 6'h36;       // Segment at 0D8000h
   localparam int         SDC_BIOS_LSB  = 16;          // 64 KB BIOS granule
   localparam logic [3:0] SDC_BIOS_TAG  = 4'hf;        // BIOS at 0F0000h
   localparam int         SDC_A_RD = 2;                // Attribute triple: read
   localparam int         SDC_A_CA = 1;                // Attribute triple: cacheable
   localparam int         SDC_A_WR = 0;                // Attribute triple: write
   localparam logic [1:0] SDC_RESP_OKAY   = 2'b00;
   localparam logic [1:0] SDC_RESP_SLVERR = 2'b10;
endpackage

// ===== verilog/sdc_regbus_if.sv
`timescale 1ns/10ps
// Register access strobes between bus slave and register bank
interface sdc_regbus_if #(parameter int AW = 12);
   logic          wr_en;     // One-cycle write pulse
   logic [AW-1:0] wr_addr;   // Byte address of write
   logic [7:0]    wr_data;   // Low byte of write data
   logic          wr_strb;   // Lane 0 strobe
   logic          wr_ok;     // Address is mapped
   logic          rd_en;     // One-cycle read pulse
   logic [AW-1:0] rd_addr;   // Byte address of read
   logic [7:0]    rd_data;   // Read value
   logic          rd_ok;     // Address is mapped
   modport bus_end (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_ok, rd_data, rd_ok);
   modport reg_end (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface // sdc_regbus_if

// ===== verilog/sdc_axil_slave.sv
`timescale 1ns/10ps
// AXI4-Lite slave front end; one write and one read in flight
module sdc_axil_slave #(
   parameter int DW = 32,
   parameter int AW = 12
) (
   input  wire logic          sys_clk,
   input  wire logic          rst,
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [DW/8-1:0] wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [DW-1:0]      rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   sdc_regbus_if.bus_end      bus
);
   logic          aw_have_q, aw_have_d;     // Write address captured
   logic          w_have_q,  w_have_d;      // Write data captured
   logic [AW-1:0] awaddr_q,  awaddr_d;
   logic [7:0]    wdata_q,   wdata_d;
   logic          wstrb_q,   wstrb_d;
   logic          awready_q, awready_d;
   logic          wready_q,  wready_d;
   logic          bvalid_q,  bvalid_d;
   logic [1:0]    bresp_q,   bresp_d;
   logic          arready_q, arready_d;
   logic          rvalid_q,  rvalid_d;
   logic [1:0]    rresp_q,   rresp_d;
   logic [DW-1:0] rdata_q,   rdata_d;

   // Commit once both halves are in and no response is pending
   assign bus.wr_en   = aw_have_q & w_have_q & ~bvalid_q;
   assign bus.wr_addr = awaddr_q;
   assign bus.wr_data = wdata_q;
   assign bus.wr_strb = wstrb_q;
   // Read is served in the handshake cycle; araddr is stable then
   assign bus.rd_en   = arvalid & arready_q;
   assign bus.rd_addr = araddr;

   // Next state of both channels
   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      if (awvalid && awready_q) begin
         aw_have_d = 1'b1;
         awaddr_d  = awaddr;
      end
      if (wvalid && wready_q) begin
         w_have_d = 1'b1;
         wdata_d  = wdata[7:0];
         wstrb_d  = wstrb[0];
      end
      if (bus.wr_en) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = bus.wr_ok ? sdc_pkg::SDC_RESP_OKAY : sdc_pkg::SDC_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (bus.rd_en) begin
         rvalid_d = 1'b1;
         rdata_d  = {{(DW-8){1'b0}}, bus.rd_data};
         rresp_d  = bus.rd_ok ? sdc_pkg::SDC_RESP_OKAY : sdc_pkg::SDC_RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      // Readies registered so outputs come from flops
      awready_d = ~aw_have_d & ~bvalid_d;
      wready_d  = ~w_have_d & ~bvalid_d;
      arready_d = ~rvalid_d;
   end

   // Registers only
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= sdc_pkg::SDC_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rresp_q   <= sdc_pkg::SDC_RESP_OKAY;
         rdata_q   <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
      end
   end

   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;
endmodule // sdc_axil_slave

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; $display("BAD %0t %h vs %h", $time, a, e); end end
module tb_top;
   logic        sys_clk = 1'b0, rst = 1'b1;               // Clock, synchronous reset
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;                       // Whole word always
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, acc_valid = 1'b0, acc_write = 1'b0, acc_pci_master = 1'b0;
   logic        dram_prog_state = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [19:0] acc_addr = 20'h00000;
   logic        acc_hit, acc_to_dram, acc_to_expansion, acc_cacheable, pbsram_b2b_en, pci_shadow_en;
   logic        refresh_advanced, aclk_to_row_strobe_two, auto_bank_en, aclk_internal_sel, dram_burst_5x_en;
   logic        enhanced_post_write_en, burst_extended_data_out_dram_write_1t, write_cas_before_ras_cycle_en;
   logic [4:0]  aclk_delay_tap;
   logic [14:0] cfg;                                      // All config levels, register bit order
   int          err_total = 0, n_tests = 0, i;
   logic [7:0]  wv [6] = '{8'hf1, 8'hb8, 8'h52, 8'h89, 8'h44, 8'hff}; // Distinct per-register values
   assign cfg = {pbsram_b2b_en, pci_shadow_en, refresh_advanced, aclk_to_row_strobe_two, auto_bank_en,
      aclk_delay_tap, aclk_internal_sel, enhanced_post_write_en, burst_extended_data_out_dram_write_1t,
      write_cas_before_ras_cycle_en, dram_burst_5x_en};
   sdc_top dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_addr, .acc_write,
      .acc_pci_master, .dram_prog_state, .acc_hit, .acc_to_dram, .acc_to_expansion, .acc_cacheable, .pbsram_b2b_en,
      .pci_shadow_en, .refresh_advanced, .aclk_to_row_strobe_two, .auto_bank_en, .aclk_delay_tap, .aclk_internal_sel,
      .enhanced_post_write_en, .burst_extended_data_out_dram_write_1t, .write_cas_before_ras_cycle_en,
      .dram_burst_5x_en);
   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;
   // Byte address of a register, four times its index
   function automatic logic [11:0] ra(input int k);
      return {2'b00, sdc_pkg::SDC_REG_IDX[k], 2'b00};
   endfunction
   // Prints the verdict and stops
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // A wait that used its whole bound is a hang
   task automatic limit(input int n);
      if (n == 60) begin
         err_total++;
         end_of_test();
      end
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      limit(i);
      `CHK(s_axi_bresp, r)
      s_axi_bready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // Read: data and response taken at the edge rvalid is seen
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      limit(i);
      `CHK(s_axi_rdata, {24'h000000, e})
      `CHK(s_axi_rresp, r)
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   // One access; result is the flop value one edge later
   task automatic acc(input logic [19:0] a, input logic w, input logic p, input logic [3:0] e);
      acc_valid      <= 1'b1;
      acc_addr       <= a;
      acc_write      <= w;
      acc_pci_master <= p;
      repeat (2) @(posedge sys_clk);
      `CHK({acc_hit, acc_to_dram, acc_to_expansion, acc_cacheable}, e)
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      for (int k = 0; k < 6; k++) rd(ra(k), 8'h00, 2'b00);
      `CHK(cfg, 15'h0000)
      $display("reset test done");
      for (int k = 0; k < 6; k++) begin
         wr(ra(k), wv[k], 2'b00);
         rd(ra(k), wv[k] & sdc_pkg::SDC_REG_MASK[k], 2'b00);
      end
      `CHK(cfg, 15'h744f)
      wr(ra(4), 8'h81, 2'b00);
      `CHK(cfg[11:4], 8'h81)
      wr(12'h200, 8'h5a, 2'b10);
      rd(12'h200, 8'h00, 2'b10);
      $display("register test done");
      acc(20'hd8000, 1'b0, 1'b0, 4'hd);
      acc(20'hdc000, 1'b1, 1'b0, 4'ha);
      acc(20'he7fff, 1'b0, 1'b0, 4'hc);
      acc(20'he4000, 1'b1, 1'b0, 4'ha);
      acc(20'he8000, 1'b0, 1'b0, 4'hb);
      acc(20'hec000, 1'b1, 1'b0, 4'hc);
      acc(20'hf0000, 1'b0, 1'b1, 4'hc);
      acc(20'hfffff, 1'b1, 1'b0, 4'ha);
      acc(20'hc0000, 1'b0, 1'b0, 4'h0);
      wr(ra(3), 8'h80, 2'b00);
      acc(20'hf0000, 1'b0, 1'b1, 4'ha);
      acc(20'hf0000, 1'b0, 1'b0, 4'hc);
      acc_valid <= 1'b0;
      $display("access test done");
      dram_prog_state <= 1'b1;
      wr(ra(5), 8'h02, 2'b00);
      `CHK(write_cas_before_ras_cycle_en, 1'b1)
      dram_prog_state <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK(write_cas_before_ras_cycle_en, 1'b0)
      rd(ra(5), 8'h00, 2'b00);
      $display("programming test done");
      end_of_test();
   end
endmodule // tb_top
